//--- design/spindle_pkg.sv
package spindle_pkg;

  // Clock and start-up timing.
  localparam int CLK_PERIOD_NS    = 5;
  localparam int STARTUP_TIME_US  = 10;
  localparam int STARTUP_CYCLES   = (STARTUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_W        = 12;

  // Torque inputs are digitised codes; the dead band is expressed in codes.
  localparam int TORQUE_W         = 8;
  localparam int DEADBAND_MV      = 50;
  localparam int CODE_STEP_MV     = 8;
  localparam logic [7:0] DEADBAND_RST = 8'(DEADBAND_MV / CODE_STEP_MV);

  // Register port.
  localparam int ADDR_W           = 8;
  localparam int DATA_W           = 32;
  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] STATUS_ADDR  = 8'h04;
  localparam int CTRL_DB_LSB      = 0;
  localparam int ST_HALL_LSB      = 0;
  localparam int ST_MARKER_BIT    = 3;
  localparam int ST_MODE_LSB      = 4;
  localparam int ST_COUNT_LSB     = 16;
  localparam int EDGE_CNT_W       = 16;

  // Hall sector code for an illegal Hall pattern.
  localparam logic [2:0] SECTOR_NONE = 3'h7;

  typedef enum logic [3:0] {
    MODE_STANDBY,
    MODE_STARTUP,
    MODE_STOP,
    MODE_FORWARD,
    MODE_IDLE,
    MODE_SHORT,
    MODE_REVERSE,
    MODE_REV_HALT
  } mode_t;

endpackage : spindle_pkg

//--- design/pwm_generator.sv
module pwm_generator #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic         run_osc,
  input  wire logic [W-1:0] duty,
  output logic              pwm_on
);
  import spindle_pkg::*;

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         pwm_r;
  logic         pwm_nxt;

  if (W < 4 || W > 16) begin : g_chk
    $error("pwm_generator: W must lie in 4..16");
  end

  // The carrier counter stands still while the oscillator is halted.
  always_comb begin
    cnt_nxt = cnt_r;
    pwm_nxt = pwm_r;
    if (clk_en) begin
      if (run_osc) begin
        cnt_nxt = cnt_r + W'(1);
        pwm_nxt = (cnt_r < duty);
      end else begin
        pwm_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      pwm_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  assign pwm_on = pwm_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_osc_halted_stable: assert property (clk_en && !run_osc |=> $stable(cnt_r) && !pwm_r)
    else $error("carrier moved while oscillator halted");
  a_pwm_duty_compare: assert property (clk_en && run_osc |=> pwm_r == ($past(cnt_r) < $past(duty)))
    else $error("pwm output does not follow duty compare");

endmodule : pwm_generator

//--- design/speed_pulse_gen.sv
module speed_pulse_gen #(
  parameter int CNT_W = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [2:0]       hall_state,
  input  wire logic             pulse_select,
  output logic                  marker,
  output logic [CNT_W-1:0]      edge_count
);
  import spindle_pkg::*;

  logic [2:0]       hall_r;
  logic [2:0]       hall_nxt;
  logic             marker_r;
  logic             marker_nxt;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  if (CNT_W < 1 || CNT_W > 16) begin : g_chk
    $error("speed_pulse_gen: CNT_W must lie in 1..16");
  end

  // The synthesized form toggles on every Hall edge, three times the single phase rate.
  always_comb begin
    hall_nxt   = hall_r;
    marker_nxt = marker_r;
    count_nxt  = count_r;
    if (clk_en) begin
      hall_nxt   = hall_state;
      marker_nxt = pulse_select ? ^hall_state : hall_state[0];
      // The register holds 000 after reset or after an all-low Hall sample; a change away from 000 is no Hall edge.
      if (hall_state != hall_r && hall_r != 3'h0) begin
        count_nxt = count_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hall_r   <= 3'h0;
      marker_r <= 1'b0;
      count_r  <= '0;
    end else begin
      hall_r   <= hall_nxt;
      marker_r <= marker_nxt;
      count_r  <= count_nxt;
    end
  end

  assign marker     = marker_r;
  assign edge_count = count_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_single_phase_marker: assert property (clk_en && !pulse_select |=> marker_r == $past(hall_state[0]))
    else $error("single phase marker does not follow Hall phase 0");
  a_synth_marker: assert property (clk_en && pulse_select |=> marker_r == ^$past(hall_state))
    else $error("synthesized marker does not follow Hall parity");

endmodule : speed_pulse_gen

//--- design/spindle_commutation_control.sv
// Summary of operation
// - Run the spindle while run/stop is high, stop driving while it is low.
// - When stopped, all high-side switches on and all low-side off: short brake.
// - In the PWM off part the active phase regenerates through the high side.
// - Duty is linear in reference minus command; forward whenever reference exceeds command by more than the dead band.
// - No forward or reverse drive while the torque difference lies inside the dead band.
// - Brake-select low and reference at or below command: short brake, high sides only.
// - Brake-select high and reference below command by more than the dead band: reverse braking torque.
// - During reverse braking, stop driving once the motor starts turning backwards.
// - The rotation marker pulse rate is proportional to motor speed.
// - Pulse-select low gives a single Hall phase, high gives three-phase synthesis.
// - Standby low puts the bridge outputs in high impedance; high operates normally.
// - In standby the internal oscillator halts.
// - After leaving standby, a start-up interval passes before normal drive.
module spindle_commutation_control #(
  parameter int PWM_W = spindle_pkg::TORQUE_W
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic                            clk_en,
  input  wire logic                            run_stop_input,
  input  wire logic                            standby_n,
  input  wire logic                            brake_select,
  input  wire logic                            pulse_select,
  input  wire logic [2:0]                      hall_state,
  input  wire logic [spindle_pkg::TORQUE_W-1:0] torque_reference,
  input  wire logic [spindle_pkg::TORQUE_W-1:0] torque_command,
  input  wire logic [spindle_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [spindle_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [spindle_pkg::DATA_W-1:0]   reg_rdata,
  output logic      [2:0]                      high_side_on,
  output logic      [2:0]                      low_side_on,
  output logic                                 bridge_oe,
  output logic                                 rotation_marker_out
);
  import spindle_pkg::*;

  localparam int TW = TORQUE_W;

  if (PWM_W != TORQUE_W) begin : g_chk
    $error("spindle_commutation_control: PWM_W must equal TORQUE_W");
  end

  // Hall pattern {h2,h1,h0} to sector 0..5 in forward rotating order.
  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    case (h)
      3'b011:  hall_sector = 3'h0;
      3'b001:  hall_sector = 3'h1;
      3'b101:  hall_sector = 3'h2;
      3'b100:  hall_sector = 3'h3;
      3'b110:  hall_sector = 3'h4;
      3'b010:  hall_sector = 3'h5;
      default: hall_sector = SECTOR_NONE;
    endcase
  endfunction : hall_sector

  // Phase whose high side sources current in a sector (U=0, V=1, W=2).
  function automatic logic [2:0] src_mask(input logic [2:0] s);
    case (s)
      3'h0, 3'h1: src_mask = 3'b100;
      3'h2, 3'h3: src_mask = 3'b010;
      3'h4, 3'h5: src_mask = 3'b001;
      default:    src_mask = 3'b000;
    endcase
  endfunction : src_mask

  // Phase whose low side sinks current in a sector.
  function automatic logic [2:0] sink_mask(input logic [2:0] s);
    case (s)
      3'h0, 3'h5: sink_mask = 3'b010;
      3'h1, 3'h2: sink_mask = 3'b001;
      3'h3, 3'h4: sink_mask = 3'b100;
      default:    sink_mask = 3'b000;
    endcase
  endfunction : sink_mask

  // Torque difference, dead band limits and duty.
  logic signed [TW:0] diff;
  logic signed [TW:0] db_s;
  logic        [TW:0] mag;
  logic        [TW:0] excess;
  logic        [TW-1:0] duty;
  logic                 above_db;
  logic                 below_db;
  logic        [7:0]    db_r;
  logic        [7:0]    db_nxt;

  always_comb begin
    diff     = $signed({1'b0, torque_reference}) - $signed({1'b0, torque_command});
    db_s     = $signed({1'b0, db_r});
    above_db = (diff > db_s);
    below_db = (diff < -db_s);
    mag      = diff[TW] ? (TW+1)'(-diff) : diff;
    excess   = mag - {1'b0, db_r};
    duty     = (mag > {1'b0, db_r}) ? excess[TW-1:0] : '0;
  end

  // Oscillator runs only out of standby.
  mode_t mode_r;
  mode_t mode_nxt;
  logic  osc_run;
  logic  pwm_on;
  assign osc_run = standby_n && (mode_r != MODE_STANDBY);

  pwm_generator #(
    .W (PWM_W)
  ) u_pwm (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .run_osc (osc_run),
    .duty    (duty),
    .pwm_on  (pwm_on)
  );

  logic [EDGE_CNT_W-1:0] edge_count;

  speed_pulse_gen #(
    .CNT_W (EDGE_CNT_W)
  ) u_speed (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .clk_en       (clk_en),
    .hall_state   (hall_state),
    .pulse_select (pulse_select),
    .marker       (rotation_marker_out),
    .edge_count   (edge_count)
  );

  // Mode, start-up timer and bridge drive.
  logic [STARTUP_W-1:0] start_cnt_r;
  logic [STARTUP_W-1:0] start_cnt_nxt;
  logic [2:0]           sector_r;
  logic [2:0]           sector_nxt;
  logic                 pwm_q_r;
  logic                 pwm_q_nxt;
  logic [2:0]           hs_r;
  logic [2:0]           hs_nxt;
  logic [2:0]           ls_r;
  logic [2:0]           ls_nxt;
  logic                 oe_r;
  logic                 oe_nxt;
  logic                 op_ready;
  logic                 rev_step;

  assign op_ready = (mode_r != MODE_STANDBY) && (mode_r != MODE_STARTUP);
  assign rev_step = (sector_r != SECTOR_NONE) && (hall_sector(hall_state) != SECTOR_NONE) &&
                    (hall_sector(hall_state) == ((sector_r == 3'h0) ? 3'h5 : sector_r - 3'h1));

  always_comb begin
    mode_nxt      = mode_r;
    start_cnt_nxt = start_cnt_r;
    sector_nxt    = hall_sector(hall_state);
    pwm_q_nxt     = pwm_on;
    if (!standby_n) begin
      mode_nxt      = MODE_STANDBY;
      start_cnt_nxt = '0;
    end else if (mode_r == MODE_STANDBY) begin
      mode_nxt      = MODE_STARTUP;
      start_cnt_nxt = '0;
    end else if (mode_r == MODE_STARTUP) begin
      start_cnt_nxt = start_cnt_r + STARTUP_W'(1);
      if (start_cnt_r == STARTUP_W'(STARTUP_CYCLES - 1)) begin
        mode_nxt = MODE_IDLE;
      end
    end else if (!run_stop_input) begin
      mode_nxt = MODE_STOP;
    end else if (above_db) begin
      mode_nxt = MODE_FORWARD;
    end else if (!brake_select && diff <= 0) begin
      mode_nxt = MODE_SHORT;
    end else if (brake_select && below_db) begin
      if (mode_r == MODE_REV_HALT || (mode_r == MODE_REVERSE && rev_step)) begin
        mode_nxt = MODE_REV_HALT;
      end else begin
        mode_nxt = MODE_REVERSE;
      end
    end else begin
      mode_nxt = MODE_IDLE;
    end

    hs_nxt = 3'b000;
    ls_nxt = 3'b000;
    oe_nxt = 1'b1;
    case (mode_nxt)
      MODE_STANDBY, MODE_STARTUP: begin
        oe_nxt = 1'b0;
      end
      MODE_STOP, MODE_SHORT: begin
        hs_nxt = 3'b111;
      end
      MODE_FORWARD: begin
        if (pwm_on) begin
          hs_nxt = src_mask(sector_nxt);
          ls_nxt = sink_mask(sector_nxt);
        end else begin
          hs_nxt = src_mask(sector_nxt) | sink_mask(sector_nxt);
        end
      end
      MODE_REVERSE: begin
        if (pwm_on) begin
          hs_nxt = sink_mask(sector_nxt);
          ls_nxt = src_mask(sector_nxt);
        end else begin
          hs_nxt = src_mask(sector_nxt) | sink_mask(sector_nxt);
        end
      end
      default: begin
        hs_nxt = 3'b000;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_r      <= MODE_STANDBY;
      start_cnt_r <= '0;
      sector_r    <= SECTOR_NONE;
      pwm_q_r     <= 1'b0;
      hs_r        <= 3'b000;
      ls_r        <= 3'b000;
      oe_r        <= 1'b0;
    end else if (clk_en) begin
      mode_r      <= mode_nxt;
      start_cnt_r <= start_cnt_nxt;
      sector_r    <= sector_nxt;
      pwm_q_r     <= pwm_q_nxt;
      hs_r        <= hs_nxt;
      ls_r        <= ls_nxt;
      oe_r        <= oe_nxt;
    end
  end

  assign high_side_on = hs_r;
  assign low_side_on  = ls_r;
  assign bridge_oe    = oe_r;

  // Register port: dead band control and status readback.
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    db_nxt    = db_r;
    rdata_nxt = '0;
    if (reg_wr && reg_addr == CTRL_ADDR) begin
      db_nxt = reg_wdata[CTRL_DB_LSB +: 8];
    end
    if (reg_rd) begin
      case (reg_addr)
        CTRL_ADDR: begin
          rdata_nxt[CTRL_DB_LSB +: 8] = db_r;
        end
        STATUS_ADDR: begin
          rdata_nxt[ST_HALL_LSB +: 3]           = hall_state;
          rdata_nxt[ST_MARKER_BIT]              = rotation_marker_out;
          rdata_nxt[ST_MODE_LSB +: 4]           = mode_r;
          rdata_nxt[ST_COUNT_LSB +: EDGE_CNT_W] = edge_count;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      db_r    <= DEADBAND_RST;
      rdata_r <= '0;
    end else if (clk_en) begin
      db_r    <= db_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_stop_mode_entry: assert property (clk_en && standby_n && op_ready && !run_stop_input
                                      |=> mode_r == MODE_STOP)
    else $error("run/stop low did not stop the spindle");
  a_stop_short_brake: assert property (mode_r == MODE_STOP |-> hs_r == 3'b111 && ls_r == 3'b000)
    else $error("stop state is not a short brake");
  a_fwd_energize_pair: assert property (mode_r == MODE_FORWARD && pwm_q_r && sector_r != SECTOR_NONE
                                        |-> hs_r == src_mask(sector_r) && ls_r == sink_mask(sector_r))
    else $error("forward drive energizes the wrong pair");
  a_pwm_off_regen: assert property (mode_r == MODE_FORWARD && !pwm_q_r
                                    |-> ls_r == 3'b000 && hs_r == (src_mask(sector_r) | sink_mask(sector_r)))
    else $error("pwm off part is not regeneration");
  a_forward_select: assert property (clk_en && standby_n && op_ready && run_stop_input && above_db
                                     |=> mode_r == MODE_FORWARD)
    else $error("reference above command did not drive forward");
  a_deadband_no_drive: assert property (clk_en && standby_n && op_ready && run_stop_input &&
                                        !above_db && diff > 0
                                        |=> hs_r == 3'b000 && ls_r == 3'b000 && oe_r)
    else $error("drive applied inside the dead band");
  a_short_brake_sel: assert property (clk_en && standby_n && op_ready && run_stop_input &&
                                      !brake_select && diff <= 0
                                      |=> hs_r == 3'b111 && ls_r == 3'b000)
    else $error("short brake not applied");
  a_reverse_pair: assert property (mode_r == MODE_REVERSE && pwm_q_r && sector_r != SECTOR_NONE
                                   |-> hs_r == sink_mask(sector_r) && ls_r == src_mask(sector_r))
    else $error("reverse brake drives the wrong pair");
  a_reverse_halt: assert property (clk_en && mode_r == MODE_REVERSE && rev_step && standby_n &&
                                   run_stop_input && brake_select && below_db
                                   |=> mode_r == MODE_REV_HALT && hs_r == 3'b000 && ls_r == 3'b000)
    else $error("reverse rotation not stopped");
  a_standby_hiz: assert property (clk_en && !standby_n |=> !oe_r && mode_r == MODE_STANDBY)
    else $error("bridge not released in standby");
  a_startup_wait: assert property ($rose(standby_n) |-> !oe_r [*8])
    else $error("drive came up before the start-up interval");

  c_forward_run: cover property (mode_r == MODE_FORWARD && pwm_q_r ##1 !pwm_q_r);
  c_reverse_halt: cover property (mode_r == MODE_REVERSE ##1 mode_r == MODE_REV_HALT);
  c_stop_brake: cover property (mode_r == MODE_FORWARD ##1 mode_r == MODE_STOP);

endmodule : spindle_commutation_control

//--- dv/hall_motor_model.sv
// Three-phase spindle motor seen through its Hall sensors: each step command
// turns the rotor one commutation sector forward or back.
module hall_motor_model (
  input  wire logic       sys_clk,
  input  wire logic       step,
  input  wire logic       dir_back,
  output logic      [2:0] hall_state
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] SEQ [6] = '{3'h3, 3'h1, 3'h5, 3'h4, 3'h6, 3'h2};
  int pos = 0;
  assign hall_state = SEQ[pos];
  always @(posedge sys_clk) begin
    if (step) begin
      pos <= dir_back ? (pos + 5) % 6 : (pos + 1) % 6;
    end
  end
endmodule : hall_motor_model

//--- dv/spindle_commutation_control_tb_top.sv
module spindle_commutation_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spindle_pkg::*;
  localparam int SRC [6] = '{4, 4, 2, 2, 1, 1};
  localparam int SNK [6] = '{2, 1, 1, 4, 4, 2};
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        run_stop_input = 1'b0, standby_n = 1'b0, brake_select = 1'b0;
  logic        pulse_select = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
  logic        step = 1'b0, dir_back = 1'b0, bridge_oe, rotation_marker_out;
  logic [7:0]  torque_reference = 8'h00, torque_command = 8'h00, reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, lfsr_s = 32'h8B0CF327;
  logic [2:0]  hall_state, high_side_on, low_side_on;
  int          bad_count = 0, check_count = 0, mpos = 0, db = 6, nsteps = 0;

  always #2.5 sys_clk = ~sys_clk;

  spindle_commutation_control dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .run_stop_input(run_stop_input), .standby_n(standby_n), .brake_select(brake_select),
    .pulse_select(pulse_select), .hall_state(hall_state), .torque_reference(torque_reference),
    .torque_command(torque_command), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_side_on(high_side_on),
    .low_side_on(low_side_on), .bridge_oe(bridge_oe), .rotation_marker_out(rotation_marker_out));
  hall_motor_model motor_u (.sys_clk(sys_clk), .step(step), .dir_back(dir_back),
    .hall_state(hall_state));

  function automatic logic [31:0] lfsr();
    lfsr_s = {lfsr_s[30:0], lfsr_s[31] ^ lfsr_s[21] ^ lfsr_s[1] ^ lfsr_s[0]};
    return lfsr_s;
  endfunction : lfsr

  task automatic tally(input bit ok, input string what, input logic [31:0] e, g);
    check_count++;
    if (!ok) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : tally
  task automatic cmp_gate(input string what, input logic [6:0] e);
    tally({bridge_oe, high_side_on, low_side_on} === e, what, 32'(e),
          32'({bridge_oe, high_side_on, low_side_on}));
  endtask : cmp_gate
  task automatic cmp_reg(input string what, input logic [31:0] e, g);
    tally(g === e, what, e, g);
  endtask : cmp_reg
  task automatic cmp_cnt(input string what, input int e, g);
    tally(g == e, what, 32'(e), 32'(g));
  endtask : cmp_cnt
  task automatic cmp_bit(input string what, input logic e);
    tally(rotation_marker_out === e, what, 32'(e), 32'(rotation_marker_out));
  endtask : cmp_bit

  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
    #1 cmp_reg("read data idle", 32'h0, reg_rdata);
  endtask : reg_read
  task automatic hall_step(input bit back);
    @(posedge sys_clk);
    step     <= 1'b1;
    dir_back <= back;
    @(posedge sys_clk);
    step     <= 1'b0;
    mpos = back ? (mpos + 5) % 6 : (mpos + 1) % 6;
    nsteps++;
    settle();
  endtask : hall_step
  task automatic set_torque(input int r, c, input logic brk);
    @(posedge sys_clk);
    torque_reference <= 8'(r);
    torque_command   <= 8'(c);
    brake_select     <= brk;
  endtask : set_torque
  // Counts on-cycles over one full carrier period and checks each gate pattern.
  task automatic measure(input int exp_on, input bit rev);
    int         on_n;
    logic [2:0] s, k;
    on_n = 0;
    s = 3'(SRC[mpos]);
    k = 3'(SNK[mpos]);
    settle();
    repeat (256) begin
      @(posedge sys_clk);
      #1;
      if (low_side_on !== 3'b000) begin
        on_n++;
        cmp_gate("drive on", rev ? {1'b1, k, s} : {1'b1, s, k});
      end else begin
        cmp_gate("drive off", {1'b1, s | k, 3'b000});
      end
    end
    cmp_cnt("on cycles", exp_on, on_n);
  endtask : measure

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end

  initial begin
    logic [31:0] d, c0;
    int          c, df;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    cmp_gate("reset", 7'h00);
    reg_read(STATUS_ADDR, d);
    cmp_reg("mode", 32'(MODE_STANDBY), 32'(d[7:4]));
    @(posedge sys_clk);
    standby_n <= 1'b1;
    repeat (STARTUP_CYCLES - 10) @(posedge sys_clk);
    #1 cmp_gate("startup", 7'h00);
    repeat (20) @(posedge sys_clk);
    #1 cmp_gate("stopped", 7'h78);
    @(posedge sys_clk);
    run_stop_input <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      c  = int'(lfsr() % 40);
      df = db + 1 + int'(lfsr() % 200);
      set_torque(c + df, c, lfsr_s[3]);
      hall_step(1'b0);
      measure(df - db, 1'b0);
    end
    set_torque(50, 47, 1'b0);
    settle();
    cmp_gate("dead band fwd", 7'h40);
    set_torque(47, 50, 1'b1);
    settle();
    cmp_gate("dead band rev", 7'h40);
    set_torque(60, 160, 1'b0);
    settle();
    cmp_gate("short brake", 7'h78);
    set_torque(90, 90, 1'b0);
    settle();
    cmp_gate("equal brake", 7'h78);
    reg_write(CTRL_ADDR, 32'h14);
    reg_read(CTRL_ADDR, d);
    cmp_reg("dead band reg", 32'h14, {24'h0, d[7:0]});
    reg_read(8'h10, d);
    cmp_reg("unmapped", 32'h0, d);
    db = 20;
    set_torque(100, 40, 1'b0);
    measure(40, 1'b0);
    set_torque(10, 150, 1'b1);
    measure(120, 1'b1);
    hall_step(1'b1);
    cmp_gate("reverse halt", 7'h40);
    reg_read(STATUS_ADDR, c0);
    cmp_reg("mode", 32'(MODE_REV_HALT), 32'(c0[7:4]));
    cmp_reg("edge count", 32'(nsteps), 32'(c0[31:16]));
    @(posedge sys_clk);
    run_stop_input <= 1'b0;
    settle();
    cmp_gate("stop", 7'h78);
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      pulse_select <= p[0];
      for (int i = 0; i < 6; i++) begin
        hall_step(1'b0);
        cmp_bit("marker", p ? ^hall_state : hall_state[0]);
      end
    end
    reg_read(STATUS_ADDR, d);
    cmp_reg("edge count", 32'(c0[31:16] + 16'd12), 32'(d[31:16]));
    @(posedge sys_clk);
    clk_en    <= 1'b0;
    standby_n <= 1'b0;
    settle();
    cmp_gate("frozen", 7'h78);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    settle();
    cmp_gate("standby", 7'h00);
    reg_read(STATUS_ADDR, d);
    cmp_reg("mode", 32'(MODE_STANDBY), 32'(d[7:4]));
    end_sim();
  end
endmodule : spindle_commutation_control_tb_top
